// ===== design/hsr_pkg.sv
// package: register map, timing constants, states and decode helpers for the resolution and ident block
package hsr_pkg;
  localparam logic [7:0] ADDR_HUM_RD = 8'h06;
  localparam logic [7:0] ADDR_TEMP_RD = 8'h11;
  localparam logic [7:0] ADDR_ID_UP = 8'h1e;
  localparam logic [7:0] ADDR_ID_LO = 8'h1f;
  localparam logic [7:0] ADDR_HUM_WR = 8'h46;
  localparam logic [7:0] ADDR_TEMP_WR = 8'h51;
  localparam logic [7:0] CMD_ENTER_PROG = 8'ha0;
  localparam logic [7:0] CMD_EXIT_PROG = 8'h80;

  localparam int REG_W = 16;
  localparam int RES_LSB = 10;
  localparam int RES_MSB = 11;
  localparam int MEAS_W = 14;
  localparam int RESULT_W = 32;
  localparam int CNT_W = 18;
  localparam int NVM_WORDS = 4;

  localparam logic [1:0] IDX_HUM = 2'h0;
  localparam logic [1:0] IDX_TEMP = 2'h1;
  localparam logic [1:0] IDX_ID_UP = 2'h2;
  localparam logic [1:0] IDX_ID_LO = 2'h3;

  localparam logic [1:0] RES_CODE_RESET = 2'h3;
  localparam logic [3:0] RES_BITS_RESET = 4'he;
  localparam logic [15:0] RES_REG_RESET = 16'h0c00;

  localparam int CLK_HZ = 10_000_000;
  localparam int T_LOAD_US = 120;
  localparam int T_WRITE_MS = 14;
  localparam int T_WINDOW_MS = 10;
  localparam int LOAD_CYC = (T_LOAD_US * (CLK_HZ / 1000) + 999) / 1000;
  localparam int WRITE_CYC = (T_WRITE_MS * (CLK_HZ / 1000));
  localparam int WINDOW_CYC = (T_WINDOW_MS * (CLK_HZ / 1000));

  typedef enum logic [1:0] {
    ST_NORMAL = 2'h0,
    ST_LOAD = 2'h1,
    ST_PROG = 2'h3,
    ST_WRITE = 2'h2
  } hsr_state_t;

  function automatic logic [3:0] hsr_res_bits(input logic [1:0] code);
    unique case (code)
      2'h0: hsr_res_bits = 4'h8;
      2'h1: hsr_res_bits = 4'ha;
      2'h2: hsr_res_bits = 4'hc;
      2'h3: hsr_res_bits = 4'he;
    endcase
  endfunction

  // output stays scaled to 14 bits; bits below the resolution read as zero
  function automatic logic [13:0] hsr_res_mask(input logic [1:0] code);
    unique case (code)
      2'h0: hsr_res_mask = 14'h3fc0;
      2'h1: hsr_res_mask = 14'h3ff0;
      2'h2: hsr_res_mask = 14'h3ffc;
      2'h3: hsr_res_mask = 14'h3fff;
    endcase
  endfunction

  function automatic logic hsr_is_read(input logic [7:0] addr);
    hsr_is_read = (addr == ADDR_HUM_RD) || (addr == ADDR_TEMP_RD) || (addr == ADDR_ID_UP) || (addr == ADDR_ID_LO);
  endfunction

  function automatic logic hsr_is_write(input logic [7:0] addr);
    hsr_is_write = (addr == ADDR_HUM_WR) || (addr == ADDR_TEMP_WR);
  endfunction

  function automatic logic [1:0] hsr_index(input logic [7:0] addr);
    if (addr == ADDR_HUM_RD || addr == ADDR_HUM_WR) begin
      hsr_index = IDX_HUM;
    end else if (addr == ADDR_TEMP_RD || addr == ADDR_TEMP_WR) begin
      hsr_index = IDX_TEMP;
    end else if (addr == ADDR_ID_UP) begin
      hsr_index = IDX_ID_UP;
    end else begin
      hsr_index = IDX_ID_LO;
    end
  endfunction
endpackage

// ===== design/hsr_nvm_if.sv
// interface: control and data between the command logic and the stored-word array
`timescale 1ns/1ps
interface hsr_nvm_if;
  logic we;
  logic [1:0] idx;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic [1:0] hum_code;
  logic [1:0] temp_code;
  modport ctl (output we, output idx, output wdata, input rdata, input hum_code, input temp_code);
  modport mem (input we, input idx, input wdata, output rdata, output hum_code, output temp_code);
endinterface

// ===== design/hsr_nvm.sv
// stored configuration words: two resolution registers and the two ident halves
`timescale 1ns/1ps
module hsr_nvm #(
  parameter logic [15:0] ID_UPPER = 16'h5a5a,
  parameter logic [15:0] ID_LOWER = 16'ha5a5
) (
  input wire logic i_core_clk,
  input wire logic i_reset,
  hsr_nvm_if.mem nvm
);
  import hsr_pkg::*;

  // the array is never touched by reset: it models non-volatile content
  logic [REG_W-1:0] mem [0:NVM_WORDS-1] = '{RES_REG_RESET, RES_REG_RESET, ID_UPPER, ID_LOWER};

  always_ff @(posedge i_core_clk) begin
    // ident words have no write address, so only the resolution words change
    if (nvm.we && (nvm.idx == IDX_HUM || nvm.idx == IDX_TEMP)) begin
      mem[nvm.idx] <= nvm.wdata;
    end
  end

  assign nvm.rdata = mem[nvm.idx];
  assign nvm.hum_code = mem[IDX_HUM][RES_MSB:RES_LSB];
  assign nvm.temp_code = mem[IDX_TEMP][RES_MSB:RES_LSB];

  nvm_hold_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    !nvm.we |=> ($stable(mem[IDX_HUM]) && $stable(mem[IDX_TEMP]) && mem[IDX_ID_UP] == ID_UPPER))
    else $error("stored word changed without a write");
  word_write_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (nvm.we && nvm.idx == IDX_TEMP) |=> (mem[IDX_TEMP] == $past(nvm.wdata) && $stable(mem[IDX_HUM])))
    else $error("full 16-bit word not stored");
endmodule

// ===== design/hsr_cfg_top.sv
// top: command handling, timed load and write phases, active resolution and result packing
`timescale 1ns/1ps
module hsr_cfg_top #(
  parameter int WINDOW_CYCLES = hsr_pkg::WINDOW_CYC,
  parameter int WRITE_CYCLES = hsr_pkg::WRITE_CYC,
  parameter logic [15:0] ID_UPPER = 16'h5a5a, // arbitrary value
  parameter logic [15:0] ID_LOWER = 16'ha5a5 // arbitrary value
) (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_cmd_valid,
  input wire logic [7:0] i_cmd_code,
  input wire logic [hsr_pkg::REG_W-1:0] i_cmd_data,
  input wire logic i_meas_valid,
  input wire logic [1:0] i_meas_status,
  input wire logic [hsr_pkg::MEAS_W-1:0] i_meas_hum,
  input wire logic [hsr_pkg::MEAS_W-1:0] i_meas_temp,
  output logic o_busy,
  output logic o_prog_mode,
  output logic o_rd_valid,
  output logic [hsr_pkg::REG_W-1:0] o_rd_data,
  output logic [3:0] o_hum_res_bits,
  output logic [3:0] o_temp_res_bits,
  output logic o_result_valid,
  output logic [hsr_pkg::RESULT_W-1:0] o_result
);
  import hsr_pkg::*;

  hsr_state_t st;
  hsr_state_t next_st;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] win_cnt;
  logic window_open;
  logic rd_pending;
  logic [1:0] rd_idx;
  logic [1:0] act_hum;
  logic [1:0] act_temp;
  logic take;
  logic phase_end;
  logic [CNT_W-1:0] rd_age;
  logic [7:0] rd_code;
  logic rd_due;

  hsr_nvm_if nvm ();

  hsr_nvm #(.ID_UPPER(ID_UPPER), .ID_LOWER(ID_LOWER)) u_nvm (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .nvm(nvm)
  );

  // commands arriving during a load or write phase are dropped, not queued
  assign take = i_cmd_valid && (st == ST_NORMAL || st == ST_PROG);
  assign phase_end = (cnt == '0);

  assign nvm.we = take && (st == ST_PROG) && hsr_is_write(i_cmd_code);
  assign nvm.idx = (st == ST_LOAD) ? rd_idx : hsr_index(i_cmd_code);
  assign nvm.wdata = i_cmd_data;

  always_comb begin
    next_st = st;
    unique case (st)
      ST_NORMAL: begin
        // entry is honoured only inside the power-up window
        if (take && i_cmd_code == CMD_ENTER_PROG && window_open) begin
          next_st = ST_LOAD;
        end
      end
      ST_PROG: begin
        if (take && i_cmd_code == CMD_EXIT_PROG) begin
          next_st = ST_NORMAL;
        end else if (take && hsr_is_read(i_cmd_code)) begin
          next_st = ST_LOAD;
        end else if (take && hsr_is_write(i_cmd_code)) begin
          next_st = ST_WRITE;
        end
      end
      ST_LOAD: begin
        if (phase_end) begin
          next_st = ST_PROG;
        end
      end
      ST_WRITE: begin
        if (phase_end) begin
          next_st = ST_PROG;
        end
      end
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      st <= ST_NORMAL;
      o_busy <= 1'b0;
      o_prog_mode <= 1'b0;
    end else begin
      st <= next_st;
      o_busy <= (next_st == ST_LOAD) || (next_st == ST_WRITE);
      o_prog_mode <= (next_st != ST_NORMAL);
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      cnt <= '0;
    end else if (next_st == ST_LOAD && st != ST_LOAD) begin
      cnt <= CNT_W'(LOAD_CYC - 1);
    end else if (next_st == ST_WRITE && st != ST_WRITE) begin
      cnt <= CNT_W'(WRITE_CYCLES - 1);
    end else if (!phase_end) begin
      cnt <= cnt - 1'b1;
    end
  end

  // window counts from reset release and saturates
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      win_cnt <= '0;
      window_open <= 1'b1;
    end else begin
      if (window_open) begin
        win_cnt <= win_cnt + 1'b1;
      end
      window_open <= (win_cnt < CNT_W'(WINDOW_CYCLES - 1));
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      rd_pending <= 1'b0;
      rd_idx <= IDX_HUM;
    end else if (take && st == ST_PROG && hsr_is_read(i_cmd_code)) begin
      rd_pending <= 1'b1;
      rd_idx <= hsr_index(i_cmd_code);
    end else if (take) begin
      rd_pending <= 1'b0;
    end else if (st == ST_LOAD && phase_end) begin
      rd_pending <= 1'b0;
    end
  end

  // read word appears only after the load time, and holds until the next command
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_rd_valid <= 1'b0;
      o_rd_data <= '0;
    end else if (st == ST_LOAD && phase_end && rd_pending) begin
      o_rd_valid <= 1'b1;
      o_rd_data <= nvm.rdata;
    end else if (take) begin
      o_rd_valid <= 1'b0;
    end
  end

  // active settings follow storage only in normal mode, so writes take effect on resume
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      act_hum <= RES_CODE_RESET;
      act_temp <= RES_CODE_RESET;
      o_hum_res_bits <= RES_BITS_RESET;
      o_temp_res_bits <= RES_BITS_RESET;
    end else begin
      if (st == ST_NORMAL) begin
        act_hum <= nvm.hum_code;
        act_temp <= nvm.temp_code;
      end
      o_hum_res_bits <= hsr_res_bits(act_hum);
      o_temp_res_bits <= hsr_res_bits(act_temp);
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_result_valid <= 1'b0;
      o_result <= '0;
    end else begin
      o_result_valid <= i_meas_valid && (st == ST_NORMAL);
      if (i_meas_valid && st == ST_NORMAL) begin
        o_result <= {i_meas_status, i_meas_hum & hsr_res_mask(act_hum),
                     i_meas_temp & hsr_res_mask(act_temp), 2'h0};
      end
    end
  end

  // checker bookkeeping: the load lasts over a thousand cycles, too long for a delay range,
  // so the age of the last read is counted here and saturates once its word is due
  assign rd_due = (rd_age == CNT_W'(LOAD_CYC + 1));

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      rd_age <= '0;
      rd_code <= '0;
    end else if (take && st == ST_PROG && hsr_is_read(i_cmd_code)) begin
      rd_age <= CNT_W'(1);
      rd_code <= i_cmd_code;
    end else if (take) begin
      rd_age <= '0;
    end else if (rd_age != '0 && !rd_due) begin
      rd_age <= rd_age + 1'b1;
    end
  end

  res_default_a: assert property (@(posedge i_core_clk)
    $fell(i_reset) |-> (o_hum_res_bits == 4'he && o_temp_res_bits == 4'he))
    else $error("resolution not 14 bits after reset");
  // the output lags the stored code by two cycles, so both of those edges must be out of reset
  res_decode_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (st == ST_NORMAL && $past(st == ST_NORMAL) && $past(st == ST_NORMAL, 2)
      && !$past(i_reset) && !$past(i_reset, 2))
    |-> (o_hum_res_bits == hsr_res_bits($past(nvm.hum_code, 2))
      && o_temp_res_bits == hsr_res_bits($past(nvm.temp_code, 2))))
    else $error("resolution bits do not match stored code");
  hum_read_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (rd_code == ADDR_HUM_RD && rd_age != '0)
    |-> (o_rd_valid == rd_due && (!o_rd_valid || o_rd_data[11:10] == nvm.hum_code)))
    else $error("humidity read word wrong or early");
  temp_read_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (rd_code == ADDR_TEMP_RD && rd_age != '0)
    |-> (o_rd_valid == rd_due && (!o_rd_valid || o_rd_data[11:10] == nvm.temp_code)))
    else $error("temperature read word missing");
  res_write_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (take && st == ST_PROG && i_cmd_code == 8'h46)
    |=> (nvm.hum_code == $past(i_cmd_data[11:10]) && st == ST_WRITE && o_busy))
    else $error("humidity write not stored");
  ident_read_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (rd_code == ADDR_ID_UP && rd_age != '0)
    |-> (o_rd_valid == rd_due && (!o_rd_valid || o_rd_data == ID_UPPER)))
    else $error("ident upper half not returned");
  result_pack_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (i_meas_valid && st == ST_NORMAL && act_temp == 2'h3 && act_hum == 2'h3)
    |=> (o_result_valid && o_result[29:16] == $past(i_meas_hum)
      && o_result[15:2] == $past(i_meas_temp) && o_result[1:0] == 2'h0))
    else $error("result bytes misplaced");
  resume_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (take && st == ST_PROG && i_cmd_code == 8'h80)
    |=> (st == ST_NORMAL) ##2 (o_hum_res_bits == hsr_res_bits(nvm.hum_code)))
    else $error("resolution not applied on resume");
  prog_hold_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (st == ST_PROG && !take) |=> ($stable(act_hum) && st == ST_PROG))
    else $error("active resolution moved in programming mode");
endmodule

// ===== tb/hsr_host_model.sv
// host-side model: sequences configuration commands toward the block
`timescale 1ns/1ps
module hsr_host_model (
  input wire logic i_core_clk,
  input wire logic i_busy,
  input wire logic i_rd_valid,
  input wire logic [15:0] i_rd_data,
  output logic o_cmd_valid,
  output logic [7:0] o_cmd_code,
  output logic [15:0] o_cmd_data
);
  import hsr_pkg::*;
  int timeouts = 0;
  initial begin
    o_cmd_valid = 1'b0;
    o_cmd_code = 8'h00;
    o_cmd_data = 16'h0000;
  end
  task automatic send(input logic [7:0] code, input logic [15:0] data);
    @(negedge i_core_clk);
    o_cmd_valid = 1'b1;
    o_cmd_code = code;
    o_cmd_data = data;
    @(negedge i_core_clk);
    o_cmd_valid = 1'b0;
    // inverted idle values, so stale bytes never look fresh
    o_cmd_code = ~code;
    o_cmd_data = ~data;
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (i_busy !== 1'b0 && n < 2000) begin
      @(negedge i_core_clk);
      n++;
    end
    if (n >= 2000) timeouts++;
  endtask
  task automatic enter_prog();
    send(CMD_ENTER_PROG, 16'h0000);
    wait_idle();
  endtask
  task automatic exit_prog();
    send(CMD_EXIT_PROG, 16'h0000);
  endtask
  task automatic read_word(input logic [7:0] addr, output logic [15:0] word);
    int n;
    n = 0;
    send(addr, 16'h0000);
    while (i_rd_valid !== 1'b1 && n < 1400) begin
      @(negedge i_core_clk);
      n++;
    end
    if (n >= 1400) timeouts++;
    word = i_rd_data;
  endtask
  task automatic set_res(input logic [7:0] rd, input logic [7:0] wr, input logic [1:0] code);
    logic [15:0] w;
    read_word(rd, w);
    w[11:10] = code;
    send(wr, w);
    wait_idle();
  endtask
endmodule

// ===== tb/tb.sv
// self-checking bench: resolution setting, ident readout and result packing
`timescale 1ns/1ps
module tb;
  import hsr_pkg::*;
  localparam logic [15:0] ID_UP = 16'h3c96; // arbitrary value
  localparam logic [15:0] ID_LO = 16'h7e18; // arbitrary value
  logic i_core_clk, i_reset, cmd_valid, meas_valid, busy, prog_mode, rd_valid, res_valid;
  logic [7:0] cmd_code;
  logic [15:0] cmd_data, rd_data;
  logic [1:0] meas_status;
  logic [13:0] meas_hum, meas_temp;
  logic [3:0] hum_bits, temp_bits;
  logic [31:0] result;
  int failures = 0;
  int check_count = 0;
  hsr_cfg_top #(.WINDOW_CYCLES(200), .WRITE_CYCLES(50), .ID_UPPER(ID_UP), .ID_LOWER(ID_LO)) u_dut (
    .i_core_clk(i_core_clk), .i_reset(i_reset), .i_cmd_valid(cmd_valid), .i_cmd_code(cmd_code),
    .i_cmd_data(cmd_data), .i_meas_valid(meas_valid), .i_meas_status(meas_status),
    .i_meas_hum(meas_hum), .i_meas_temp(meas_temp), .o_busy(busy), .o_prog_mode(prog_mode),
    .o_rd_valid(rd_valid), .o_rd_data(rd_data), .o_hum_res_bits(hum_bits),
    .o_temp_res_bits(temp_bits), .o_result_valid(res_valid), .o_result(result));
  hsr_host_model u_host (
    .i_core_clk(i_core_clk), .i_busy(busy), .i_rd_valid(rd_valid), .i_rd_data(rd_data),
    .o_cmd_valid(cmd_valid), .o_cmd_code(cmd_code), .o_cmd_data(cmd_data));
  function automatic logic [31:0] bits(input logic [1:0] c);
    bits = {28'h0, 4'h8 + {1'b0, c, 1'b0}};
  endfunction
  function automatic logic [31:0] exp_res(input logic [1:0] s, input logic [13:0] h,
      input logic [13:0] t, input logic [1:0] ch, input logic [1:0] ct);
    // low bits under the active resolution read as zero, output stays 14-bit scaled
    exp_res = {s, h & (14'h3fff << (6 - 2 * int'(ch))), t & (14'h3fff << (6 - 2 * int'(ct))), 2'h0};
  endfunction
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic complete_run();
    failures += u_host.timeouts;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // host-side conversion to percent and degrees, integer truncated
  function automatic int scale(input logic [13:0] c, input int span);
    scale = int'(c) * span / 16383;
  endfunction
  task automatic measure(input logic [1:0] ch, input logic [1:0] ct);
    logic [31:0] e;
    @(negedge i_core_clk);
    meas_valid = 1'b1;
    meas_status = 2'($urandom);
    meas_hum = 14'($urandom);
    meas_temp = 14'($urandom);
    e = exp_res(meas_status, meas_hum, meas_temp, ch, ct);
    @(negedge i_core_clk);
    meas_valid = 1'b0;
    for (int k = 0; k < 3 && res_valid !== 1'b1; k++) @(negedge i_core_clk);
    check("result valid", 32'h1, {31'h0, res_valid});
    check("result", e, result);
    check("hum percent", 32'(scale(e[29:16], 100)), 32'(scale(result[29:16], 100)));
    check("temp celsius", 32'(scale(e[15:2], 165) - 40), 32'(scale(result[15:2], 165) - 40));
  endtask
  task automatic do_reset();
    @(negedge i_core_clk);
    i_reset = 1'b1;
    repeat (4) @(negedge i_core_clk);
    i_reset = 1'b0;
  endtask
  initial begin
    i_core_clk = 1'b0;
    forever #50 i_core_clk = ~i_core_clk;
  end
  initial begin
    repeat (90000) @(posedge i_core_clk);
    failures++;
    complete_run();
  end
  initial begin
    logic [15:0] w;
    logic [1:0] hc, tc, nh, nt;
    i_reset = 1'b1;
    meas_valid = 1'b0;
    meas_status = 2'h0;
    meas_hum = 14'h0;
    meas_temp = 14'h0;
    void'($urandom(32'h6884225f));
    hc = 2'h3;
    tc = 2'h3;
    for (int i = 0; i < 5; i++) begin
      do_reset();
      repeat (4) @(negedge i_core_clk);
      check("hum bits after reset", bits(hc), {28'h0, hum_bits});
      check("temp bits after reset", bits(tc), {28'h0, temp_bits});
      measure(hc, tc);
      u_host.enter_prog();
      check("prog mode", 32'h1, {31'h0, prog_mode});
      u_host.read_word(ADDR_HUM_RD, w);
      check("hum word", {20'h0, hc, 10'h0}, {16'h0, w});
      u_host.read_word(ADDR_TEMP_RD, w);
      check("temp word", {20'h0, tc, 10'h0}, {16'h0, w});
      u_host.read_word(ADDR_ID_UP, w);
      check("ident upper", {16'h0, ID_UP}, {16'h0, w});
      u_host.read_word(ADDR_ID_LO, w);
      check("ident lower", {16'h0, ID_LO}, {16'h0, w});
      nh = (i < 4) ? i[1:0] : 2'($urandom);
      nt = (i < 4) ? 2'(3 - i) : 2'($urandom);
      u_host.set_res(ADDR_HUM_RD, ADDR_HUM_WR, nh);
      u_host.set_res(ADDR_TEMP_RD, ADDR_TEMP_WR, nt);
      check("hum bits frozen", bits(hc), {28'h0, hum_bits});
      u_host.exit_prog();
      repeat (4) @(negedge i_core_clk);
      hc = nh;
      tc = nt;
      check("prog left", 32'h0, {31'h0, prog_mode});
      check("hum bits", bits(hc), {28'h0, hum_bits});
      check("temp bits", bits(tc), {28'h0, temp_bits});
      measure(hc, tc);
    end
    // entry after the power-up window must be dropped
    repeat (250) @(negedge i_core_clk);
    u_host.send(CMD_ENTER_PROG, 16'h0000);
    repeat (2) @(negedge i_core_clk);
    check("late entry", 32'h0, {31'h0, prog_mode});
    complete_run();
  end
endmodule
